// >>> hdl/special_input_event_unit.sv
// Operation
// - catch input keeps only the first selected edge in each scan
// - catch status flag is set for exactly one scan, then clears
// - catch edge per group is rising or falling
// - six inputs can be interrupt sources on rising, falling or both edges
// - interrupt dispatch presents that source's jump label at once
// - each group takes one function: normal, capture, interrupt, frequency; the counter mode code drives no logic
// - normal inputs are sampled only at end of scan
// - all interrupts enabled by default; enable and disable commands per source
// - one enabled flag per interrupt input mirrors its enable state
// - calls in a handler nest three deep; deeper raises error flag and lamp
// - simultaneous interrupts served from group one upward
// - a running handler is never preempted; new requests wait
// - smallest variant has no interrupt on groups five and six
// - frequency measured by own logic, published once per scan
// - each frequency is a read-only 32-bit upper and lower word pair
// - whole hertz truncated; 1 Hz or 200 Hz up to 100 kHz
// - slow input publishes after one pulse period plus one scan
// - upper and lower word placement follows the word-order setting
// - groups not measuring stay usable for other functions
// - no frequency on AC variants nor on groups five, six of smallest
// - catch inputs take pulses of 5 us or more, shorter than a scan
// - each catch input has its own status flag in group order
`timescale 1ns/10ps
`default_nettype none
`include "sieu_params.svh"
module special_input_event_unit #(
   parameter int unsigned CLK_HZ        = `CLK_HZ,
   parameter int unsigned LO_MAX_PER    = `LO_MAX_PER,
   parameter int unsigned HI_MAX_PER    = `HI_MAX_PER,
   parameter bit          SMALL_VARIANT = 1'b0,
   parameter bit          AC_POWER      = 1'b0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        source_input_1,
   input  wire logic        source_input_2,
   input  wire logic        source_input_3,
   input  wire logic        source_input_4,
   input  wire logic        source_input_5,
   input  wire logic        source_input_6,
   input  wire logic        scan_end_strobe,
   input  wire logic        running_flag,
   input  wire logic        handler_return_cmd,
   input  wire logic        sub_call_cmd,
   input  wire logic        sub_return_cmd,
   output var  logic        irq_req,
   output var  logic [15:0] irq_label,
   output var  logic [2:0]  irq_src,
   output var  logic        handler_active,
   output var  logic [5:0]  irq_enabled_flags,
   output var  logic [5:0]  capture_status_flags,
   output var  logic [5:0]  normal_inputs,
   output var  logic        exec_error_flag,
   output var  logic        error_indicator
);
   import sieu_pkg::*;

   if (HI_MAX_PER == 0 || HI_MAX_PER > LO_MAX_PER || CLK_HZ < `FREQ_MAX_HZ
       || `CATCH_MIN_CYC < 1) begin : g_bad
      $error("unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [5:0] mode_mask(logic [5:0][2:0] m, mode_t k);
      logic [5:0] r;
      for (int i = 0; i < 6; i++) begin
         r[i] = (m[i] == k);
      end
      return r;
   endfunction

   function automatic logic [5:0] edge_hits(logic [5:0] cur, logic [5:0] prv,
                                            logic [5:0] rs, logic [5:0] fs);
      return (cur & ~prv & rs) | (~cur & prv & fs);
   endfunction

   function automatic logic [2:0] first_set(logic [5:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 5; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   function automatic logic in_win(logic [11:0] a, logic [11:0] base, logic [3:0] n);
      return a >= base && a < base + {6'h00, n, 2'h0} && a[1:0] == 2'h0;
   endfunction

   function automatic logic [3:0] win_idx(logic [11:0] a, logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return d[5:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   state_t      s;
   state_t      next_s;
   logic [5:0]  pins;
   logic [5:0]  avail;
   logic [5:0]  fmask;
   logic [31:0] lim [6];

   // smallest variant loses groups five and six for every special function
   assign pins  = {source_input_6, source_input_5, source_input_4,
                   source_input_3, source_input_2, source_input_1};
   assign avail = SMALL_VARIANT ? 6'h0F : 6'h3F;
   assign fmask = mode_mask(s.mode, MD_FREQ) & avail & {6{!AC_POWER}};
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         lim[i] = (i < 4) ? 32'(LO_MAX_PER) : 32'(HI_MAX_PER);
      end
   end

   always_comb begin
      logic [11:0] a;
      logic        wr;
      logic [3:0]  ix;
      logic [5:0]  nmask;
      logic [5:0]  cmask;
      logic [5:0]  imask;
      logic [5:0]  crs;
      logic [5:0]  irs;
      logic [5:0]  ifs;
      logic [5:0]  cedge;
      logic [5:0]  iedge;
      logic [5:0]  take;
      logic [2:0]  g;
      logic [32:0] t;
      logic [32:0] rn;
      logic        q;
      a     = paddr;
      wr    = psel & penable & s.pready & pwrite;
      ix    = 4'h0;
      take  = 6'h00;
      g     = 3'h0;
      t     = 33'h0;
      rn    = 33'h0;
      q     = 1'b0;
      crs   = 6'h00;
      irs   = 6'h00;
      ifs   = 6'h00;
      cedge = 6'h00;
      iedge = 6'h00;
      nmask = 6'h00;
      cmask = 6'h00;
      imask = 6'h00;
      next_s = s;
      nmask = mode_mask(s.mode, MD_NORMAL);
      cmask = mode_mask(s.mode, MD_CAPTURE) & avail;
      imask = mode_mask(s.mode, MD_IRQ) & avail;
      for (int i = 0; i < 6; i++) begin
         crs[i] = s.edg[i][0];
         irs[i] = s.edg[i][0];
         ifs[i] = s.edg[i][1];
      end

      // apb: answer in the cycle after setup, zero wait states
      next_s.pready  = psel & ~penable;
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
      if (psel & ~penable) begin
         if (in_win(a, `OFS_LABEL, `N_LABEL)) begin
            ix = win_idx(a, `OFS_LABEL);
            next_s.prdata = {16'h0000, s.label[ix[2:0]]};
         end else if (in_win(a, `OFS_FREQ, `N_FREQ)) begin
            ix = win_idx(a, `OFS_FREQ);
            // word order swaps which address holds the upper half
            if (ix[0] ^ ~s.word_order) begin
               next_s.prdata = {16'h0000, s.fpub[ix[3:1]][31:16]};
            end else begin
               next_s.prdata = {16'h0000, s.fpub[ix[3:1]][15:0]};
            end
         end else begin
            unique case (a)
               `OFS_MODE:     next_s.prdata = {14'h0000, s.mode};
               `OFS_EDGE:     next_s.prdata = {20'h00000, s.edg};
               `OFS_CTRL:     next_s.prdata = {31'h0, s.word_order};
               `OFS_IRQ_CMD:  next_s.prdata = 32'h0000_0000;
               `OFS_IRQ_STAT: next_s.prdata = {13'h0000, s.depth, s.hact, 2'h0,
                                               s.pend, 1'b0, s.ena};
               `OFS_CAPT:     next_s.prdata = {26'h0, s.capt};
               `OFS_NORM:     next_s.prdata = {26'h0, s.norm};
               `OFS_ERR:      next_s.prdata = {31'h0, s.err};
               default:       next_s.pslverr = 1'b1;
            endcase
         end
      end
      if (wr) begin
         if (in_win(a, `OFS_LABEL, `N_LABEL)) begin
            ix = win_idx(a, `OFS_LABEL);
            next_s.label[ix[2:0]] = pwdata[15:0];
         end
         unique case (a)
            `OFS_MODE:    next_s.mode = pwdata[17:0];
            `OFS_EDGE:    next_s.edg = pwdata[11:0];
            `OFS_CTRL:    next_s.word_order = pwdata[0];
            // disable wins over enable when both bits are written
            `OFS_IRQ_CMD: next_s.ena = (s.ena | pwdata[`CMD_EN_LSB +: 7])
                                       & ~pwdata[`CMD_DIS_LSB +: 7];
            `OFS_ERR:     if (pwdata[0]) next_s.err = 1'b0;
            default:      ;
         endcase
      end

      // catch inputs and normal sampling on the scan boundary
      next_s.pin_q = pins;
      cedge = edge_hits(pins, s.pin_q, crs, ~crs) & cmask;
      if (scan_end_strobe) begin
         next_s.capt     = s.cap_seen & cmask;
         next_s.cap_seen = cedge;
         next_s.norm     = pins & nmask;
      end else begin
         // later pulses in the same scan fold into the held bit
         next_s.cap_seen = s.cap_seen | cedge;
      end

      // interrupt dispatch
      next_s.irq_req = 1'b0;
      iedge = edge_hits(pins, s.pin_q, irs, ifs) & imask & {6{running_flag}};
      if (!s.hact && (|s.pend)) begin
         g = first_set(s.pend);
         take = 6'h01 << g;
         next_s.irq_req   = 1'b1;
         next_s.irq_label = s.label[g];
         next_s.irq_src   = g;
         next_s.hact      = 1'b1;
         next_s.depth     = 2'h0;
      end else if (s.hact && handler_return_cmd) begin
         next_s.hact  = 1'b0;
         next_s.depth = 2'h0;
      end
      // a disabled source drops its waiting request
      next_s.pend = ((s.pend & ~take) | iedge) & next_s.ena[5:0] & imask;
      if (s.hact && sub_call_cmd) begin
         if (s.depth == `NEST_MAX) begin
            next_s.err = 1'b1;
         end else begin
            next_s.depth = s.depth + 2'h1;
         end
      end else if (s.hact && sub_return_cmd && s.depth != 2'h0) begin
         next_s.depth = s.depth - 2'h1;
      end

      // shared reciprocal divider: hertz = clock rate / period cycles
      unique case (s.dst)
         DIV_IDLE: begin
            if (|s.per_new) begin
               g = first_set(s.per_new);
               next_s.per_new[g] = 1'b0;
               next_s.dgrp = g;
               next_s.dden = s.per_val[g];
               next_s.dnum = 32'(CLK_HZ);
               next_s.drem = 32'h0;
               next_s.dcnt = 5'h00;
               next_s.dst  = DIV_RUN;
            end
         end
         DIV_RUN: begin
            t = {s.drem, s.dnum[31]};
            q = (t >= {1'b0, s.dden});
            rn = q ? t - {1'b0, s.dden} : t;
            next_s.drem = rn[31:0];
            next_s.dnum = {s.dnum[30:0], q};
            next_s.dcnt = s.dcnt + 5'h01;
            if (s.dcnt == 5'h1F) begin
               next_s.dst = DIV_DONE;
            end
         end
         DIV_DONE: begin
            next_s.fcalc[s.dgrp] = s.dnum;
            next_s.dst = DIV_IDLE;
         end
         default: next_s.dst = DIV_IDLE;
      endcase

      // period capture runs every cycle, independent of the scan
      for (int i = 0; i < 6; i++) begin
         if (fmask[i]) begin
            if (pins[i] && !s.pin_q[i]) begin
               if (s.per_arm[i] && s.per_cnt[i] <= lim[i]) begin
                  next_s.per_val[i] = s.per_cnt[i];
                  next_s.per_new[i] = 1'b1;
               end else if (s.per_arm[i]) begin
                  next_s.fcalc[i] = 32'h0;
               end
               next_s.per_arm[i] = 1'b1;
               next_s.per_cnt[i] = 32'h1;
            end else if (s.per_cnt[i] <= lim[i]) begin
               next_s.per_cnt[i] = s.per_cnt[i] + 32'h1;
            end else begin
               // below range: the input has stopped or is too slow
               next_s.fcalc[i] = 32'h0;
            end
         end else begin
            next_s.per_arm[i] = 1'b0;
            next_s.per_new[i] = 1'b0;
            next_s.fcalc[i]   = 32'h0;
         end
         if (scan_end_strobe) begin
            next_s.fpub[i] = fmask[i] ? s.fcalc[i] : 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s      <= '0;
         s.mode <= `RST_MODE;
         s.edg  <= `RST_EDGE;
         s.ena  <= `RST_ENA;
      end else begin
         s <= next_s;
      end
   end

   assign prdata               = s.prdata;
   assign pready               = s.pready;
   assign pslverr              = s.pslverr;
   assign irq_req              = s.irq_req;
   assign irq_label            = s.irq_label;
   assign irq_src              = s.irq_src;
   assign handler_active       = s.hact;
   assign irq_enabled_flags    = s.ena[5:0];
   assign capture_status_flags = s.capt;
   assign normal_inputs        = s.norm;
   assign exec_error_flag      = s.err;
   assign error_indicator      = s.err;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_dis_wr;
      psel && penable && pready && pwrite && paddr == `OFS_IRQ_CMD && pwdata[`CMD_DIS_LSB];
   endsequence
   sequence s_deep_call;
      handler_active && s.depth == 2'h3 && sub_call_cmd;
   endsequence

   AST_CAPT_AT_SCAN: assert property ($changed(capture_status_flags) |-> $past(scan_end_strobe))
      else $error("capture flags changed off scan boundary");
   AST_CATCH_HELD: assert property (!scan_end_strobe |=> (s.cap_seen & $past(s.cap_seen)) == $past(s.cap_seen))
      else $error("caught edge lost inside scan");
   AST_LABEL: assert property (irq_req |-> irq_label == s.label[irq_src])
      else $error("dispatched label mismatch");
   AST_NO_PREEMPT: assert property (handler_active && !handler_return_cmd |=> !irq_req)
      else $error("handler preempted");
   AST_PRIORITY: assert property (irq_req |-> ($past(s.pend) & ((6'h01 << irq_src) - 6'h01)) == 6'h00)
      else $error("lower group skipped");
   AST_NEST_ERR: assert property (s_deep_call |=> exec_error_flag && error_indicator)
      else $error("nesting overflow not flagged");
   AST_DISABLE: assert property (s_dis_wr |=> !irq_enabled_flags[0] ##1 !s.pend[0])
      else $error("disable command ignored");
   AST_NORM_AT_SCAN: assert property ($changed(normal_inputs) |-> $past(scan_end_strobe))
      else $error("normal input sampled mid scan");
   AST_SMALL: assert property (!(SMALL_VARIANT && (|s.pend[5:4])))
      else $error("small variant pending on group five or six");
   AST_FREQ_AT_SCAN: assert property ($changed(s.fpub) |-> $past(scan_end_strobe))
      else $error("frequency published off scan boundary");
   AST_IRQ_OWNS: assert property (irq_req |-> handler_active)
      else $error("dispatch without active handler");
endmodule
`default_nettype wire

// >>> include/sieu_params.svh
`ifndef SIEU_PARAMS_SVH
`define SIEU_PARAMS_SVH
// clock and timing
`define CLK_HZ          10000000
`define CLK_PERIOD_NS   100
`define CATCH_MIN_NS    5000
`define CATCH_MIN_CYC   ((`CATCH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FREQ_MIN_LO_HZ  1
`define FREQ_MIN_HI_HZ  200
`define FREQ_MAX_HZ     100000
`define LO_MAX_PER      (`CLK_HZ / `FREQ_MIN_LO_HZ)
`define HI_MAX_PER      (`CLK_HZ / `FREQ_MIN_HI_HZ)
`define NEST_MAX        2'd3
// register byte offsets
`define OFS_MODE        12'h000
`define OFS_EDGE        12'h004
`define OFS_CTRL        12'h008
`define OFS_IRQ_CMD     12'h00C
`define OFS_IRQ_STAT    12'h010
`define OFS_CAPT        12'h014
`define OFS_NORM        12'h018
`define OFS_ERR         12'h01C
`define OFS_LABEL       12'h020
`define OFS_FREQ        12'h040
`define N_LABEL         4'd6
`define N_FREQ          4'd12
// field positions
`define CMD_EN_LSB      0
`define CMD_DIS_LSB     8
`define STAT_PEND_LSB   8
`define STAT_ACT_BIT    16
`define STAT_DEPTH_LSB  17
// reset values
`define RST_MODE        18'h00000
`define RST_EDGE        12'h555
`define RST_ENA         7'h7F
`endif

// >>> include/sieu_pkg.sv
`default_nettype none
package sieu_pkg;
   typedef enum logic [2:0] {
      MD_NORMAL  = 3'h0,
      MD_COUNTER = 3'h1,
      MD_CAPTURE = 3'h2,
      MD_IRQ     = 3'h3,
      MD_FREQ    = 3'h4
   } mode_t;
   typedef enum logic [1:0] {
      DIV_IDLE = 2'h0,
      DIV_RUN  = 2'h1,
      DIV_DONE = 2'h3
   } div_state_t;
   typedef struct packed {
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      logic [5:0][2:0]   mode;
      logic [5:0][1:0]   edg;
      logic              word_order;
      logic [6:0]        ena;
      logic [5:0][15:0]  label;
      logic [5:0]        pin_q;
      logic [5:0]        cap_seen;
      logic [5:0]        capt;
      logic [5:0]        norm;
      logic [5:0]        pend;
      logic              hact;
      logic [1:0]        depth;
      logic              irq_req;
      logic [15:0]       irq_label;
      logic [2:0]        irq_src;
      logic              err;
      logic [5:0][31:0]  per_cnt;
      logic [5:0][31:0]  per_val;
      logic [5:0][31:0]  fcalc;
      logic [5:0][31:0]  fpub;
      logic [5:0]        per_arm;
      logic [5:0]        per_new;
      div_state_t        dst;
      logic [2:0]        dgrp;
      logic [4:0]        dcnt;
      logic [31:0]       dnum;
      logic [31:0]       drem;
      logic [31:0]       dden;
   } state_t;
endpackage
`default_nettype wire

// >>> tb/field_input_model.sv
`timescale 1ns/10ps
`default_nettype none
module field_input_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [5:0]  wave_en,
   input  wire logic [15:0] half_per,
   output var  logic [5:0]  pins
);
   logic [5:0]  lvl;
   logic [15:0] cnt;
   initial lvl = 6'h00;
   // levels move only at clock edges, never mid-cycle
   task automatic set_pin(input int g, input logic v);
      lvl[g] <= v;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // square wave shared by all groups in wave mode
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= 6'h00;
         cnt  <= 16'h0000;
      end else begin
         cnt <= (cnt + 16'h0001 >= half_per) ? 16'h0000 : cnt + 16'h0001;
         for (int g = 0; g < 6; g++) begin
            pins[g] <= wave_en[g] ? (pins[g] ^ (cnt == 16'h0000)) : lvl[g];
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/special_input_event_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sieu_params.svh"
module special_input_event_unit_tb;
   logic        pclk, presetn, psel, penable, pwrite, scan, run;
   logic        pready, pslverr, irq_req, handler_active, exec_error_flag, error_indicator;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] irq_label, half_per;
   logic [2:0]  irq_src, cmd;
   logic [5:0]  pins, wave_en, en_f, cap_f, norm_f;
   int          error_cnt, n_compared, cyc = 0;
   // short period limits keep the run brief
   special_input_event_unit #(.LO_MAX_PER(2000), .HI_MAX_PER(500)) u_special_input_event_unit (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .source_input_1(pins[0]), .source_input_2(pins[1]), .source_input_3(pins[2]),
      .source_input_4(pins[3]), .source_input_5(pins[4]), .source_input_6(pins[5]),
      .scan_end_strobe(scan), .running_flag(run), .handler_return_cmd(cmd[0]),
      .sub_call_cmd(cmd[1]), .sub_return_cmd(cmd[2]), .irq_req(irq_req),
      .irq_label(irq_label), .irq_src(irq_src), .handler_active(handler_active),
      .irq_enabled_flags(en_f), .capture_status_flags(cap_f), .normal_inputs(norm_f),
      .exec_error_flag(exec_error_flag), .error_indicator(error_indicator));
   field_input_model u_field_input_model (.clk(pclk), .rst_n(presetn), .wave_en(wave_en),
      .half_per(half_per), .pins(pins));
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // waits on pready alone; only the hang guard ends a stuck transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(rd, exp);
   endtask
   task automatic scan_end();
      @(posedge pclk);
      scan <= 1'b1;
      @(posedge pclk);
      scan <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic pulse(input logic [2:0] c);
      @(posedge pclk);
      cmd <= c;
      @(posedge pclk);
      cmd <= 3'h0;
      @(posedge pclk);
   endtask
   task automatic pin(input int g, input logic v);
      @(posedge pclk);
      u_field_input_model.set_pin(g, v);
   endtask
   task automatic wait_irq(input logic [2:0] s);
      int w;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (irq_req !== 1'b1 && w < 20);
      chk({28'h0, irq_req, irq_src}, {28'h0, 1'b1, s});
      chk({15'h0, handler_active, irq_label}, {15'h0, 1'b1, 16'h1000 + {13'h0, s}});
   endtask
   task automatic no_irq(input int n);
      repeat (n) begin
         @(posedge pclk);
         chk({31'h0, irq_req}, 32'h0);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // hang guard, the sequence needs about 4000 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, scan, cmd} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      run = 1'b1;
      wave_en = 6'h00;
      half_per = 16'h01F4;
      error_cnt = 0;
      n_compared = 0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({26'h0, en_f}, 32'h3F);
      rdchk(`OFS_MODE, 32'h0);
      rdchk(`OFS_EDGE, 32'h555);
      rdchk(`OFS_IRQ_STAT, 32'h7F);
      apb(1'b0, 12'hFFC, 32'h0, 1'b1);
      for (int g = 0; g < 6; g++) wr(12'(32 + 4 * g), 32'h1000 + 32'(g));
      for (int g = 0; g < 6; g++) rdchk(12'(32 + 4 * g), 32'h1000 + 32'(g));
      // group1 catches rising, group2 falling, group3 stays normal
      pin(2, 1'b1);
      pin(1, 1'b1);
      repeat (5) @(posedge pclk);
      chk({26'h0, norm_f}, 32'h0);
      wr(`OFS_MODE, 32'h12);
      wr(`OFS_EDGE, 32'h551);
      pin(0, 1'b1);
      repeat (60) @(posedge pclk);
      pin(0, 1'b0);
      repeat (60) @(posedge pclk);
      pin(0, 1'b1);
      pin(1, 1'b0);
      repeat (60) @(posedge pclk);
      chk({26'h0, cap_f}, 32'h0);
      scan_end();
      chk({20'h0, norm_f, cap_f}, 32'h103);
      scan_end();
      chk({26'h0, cap_f}, 32'h0);
      // interrupts: group1 rising, group2 falling, group3 both edges
      pin(0, 1'b0);
      wr(`OFS_MODE, 32'hDB);
      wr(`OFS_EDGE, 32'h579);
      @(posedge pclk);
      u_field_input_model.set_pin(0, 1'b1);
      u_field_input_model.set_pin(2, 1'b0);
      wait_irq(3'd0);
      no_irq(10);
      pulse(3'b001);
      wait_irq(3'd2);
      pulse(3'b001);
      pin(1, 1'b1);
      no_irq(10);
      pin(1, 1'b0);
      wait_irq(3'd1);
      // handler body only calls and returns, no enable or disable inside
      repeat (3) pulse(3'b010);
      chk({31'h0, exec_error_flag}, 32'h0);
      pulse(3'b010);
      chk({30'h0, exec_error_flag, error_indicator}, 32'h3);
      rdchk(`OFS_ERR, 32'h1);
      repeat (3) pulse(3'b100);
      pulse(3'b001);
      wr(`OFS_ERR, 32'h1);
      rdchk(`OFS_ERR, 32'h0);
      wr(`OFS_IRQ_CMD, 32'h100);
      @(posedge pclk);
      chk({26'h0, en_f}, 32'h3E);
      pin(0, 1'b0);
      pin(0, 1'b1);
      no_irq(10);
      wr(`OFS_IRQ_CMD, 32'h1);
      @(posedge pclk);
      chk({26'h0, en_f}, 32'h3F);
      // stopped controller takes no interrupt edges
      run <= 1'b0;
      pin(0, 1'b0);
      pin(0, 1'b1);
      no_irq(10);
      run <= 1'b1;
      // groups 4 and 5 measure a 10 kHz wave; group5 limit lies above it
      wr(`OFS_MODE, 32'h4800);
      wave_en <= 6'h18;
      repeat (3500) @(posedge pclk);
      rdchk(12'h05C, 32'h0);
      scan_end();
      rdchk(12'h058, 32'h0);
      rdchk(12'h05C, 32'h2710);
      rdchk(12'h064, 32'h0);
      wr(12'h05C, 32'hFFFF);
      rdchk(12'h05C, 32'h2710);
      wr(`OFS_CTRL, 32'h1);
      rdchk(12'h058, 32'h2710);
      rdchk(12'h05C, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
